// ==== core/ndma_params.svh ====
// Timing, threshold and reset constants of the network DMA engine.
`ifndef NDMA_PARAMS_SVH
`define NDMA_PARAMS_SVH

// ----------------------------------------------------------------
// Staging buffer
// ----------------------------------------------------------------
`define NDMA_SILO_BYTES     48
`define NDMA_SILO_AW        6
`define NDMA_TX_REQ_FREE    16
`define NDMA_BACKOFF_FILL   32
`define NDMA_RX_BURST_MIN   16
`define NDMA_RX_STOP_LEVEL  46

// ----------------------------------------------------------------
// Bus cycle timing
// ----------------------------------------------------------------
`define NDMA_CLK_PERIOD_NS  40
`define NDMA_BUS_CYC_NS     600
`define NDMA_BUS_CYC_CLKS   ((`NDMA_BUS_CYC_NS + `NDMA_CLK_PERIOD_NS - 1) / `NDMA_CLK_PERIOD_NS)
`define NDMA_ADDR_CLKS      3
`define NDMA_BURST_XFERS    8

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define NDMA_RST_ACT_LOW    1'b1
`define NDMA_RST_ACT_HIGH   1'b0

`endif

// ==== core/ndma_pkg.sv ====
// Types shared by the network DMA engine modules.
`default_nettype none
package ndma_pkg;

   typedef enum logic [9:0] {
      st_idle = 10'h001,
      st_req  = 10'h002,
      st_load = 10'h004,
      st_addr = 10'h008,
      st_turn = 10'h010,
      st_strb = 10'h020,
      st_hold = 10'h040,
      st_push = 10'h080,
      st_next = 10'h100,
      st_rel  = 10'h200
   } ndma_state_e;

   typedef struct packed {
      logic [5:0] wp;
      logic [5:0] rp;
      logic [5:0] cnt;
   } ndma_silo_s;

   typedef struct packed {
      logic [7:0] d0;
      logic [7:0] d1;
      logic [1:0] cnt;
      logic       vld;
      logic       rdy;
   } ndma_skid_s;

endpackage
`default_nettype wire

// ==== core/ndma_silo.sv ====
// Byte-wide 48-entry staging buffer between bus side and serial side.
`include "ndma_params.svh"
`default_nettype none
module ndma_silo
   import ndma_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_ce,
   // Fill side
   input  wire logic       i_push,
   input  wire logic [7:0] i_push_data,
   // Drain side
   input  wire logic       i_pop,
   output logic      [7:0] o_data,
   output logic      [5:0] o_count
);

   localparam logic [5:0] LAST = 6'(`NDMA_SILO_BYTES - 1);

   logic [7:0] mem [`NDMA_SILO_BYTES];
   ndma_silo_s r_ff;
   ndma_silo_s nxt_r;
   logic       do_push;
   logic       do_pop;

   always_comb begin
      nxt_r   = r_ff;
      do_push = i_push && (r_ff.cnt != 6'(`NDMA_SILO_BYTES));
      do_pop  = i_pop && (r_ff.cnt != 6'h00);
      if (do_push) begin
         nxt_r.wp = (r_ff.wp == LAST) ? 6'h00 : r_ff.wp + 6'h01;
      end
      if (do_pop) begin
         nxt_r.rp = (r_ff.rp == LAST) ? 6'h00 : r_ff.rp + 6'h01;
      end
      nxt_r.cnt = r_ff.cnt + 6'(do_push) - 6'(do_pop);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r_ff <= '0;
      end else if (i_ce) begin
         r_ff <= nxt_r;
      end
   end

   // Storage has no reset; only the pointers define what is valid.
   always_ff @(posedge i_sys_clk) begin
      if (i_ce && do_push) begin
         mem[r_ff.wp] <= i_push_data;
      end
   end

   assign o_data  = mem[r_ff.rp];
   assign o_count = r_ff.cnt;

endmodule
`default_nettype wire

// ==== core/ndma_skid.sv ====
// Two-entry buffer with valid and ready on both sides.
`default_nettype none
module ndma_skid
   import ndma_pkg::*;
(
   // Clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_srst,
   input  wire logic       i_ce,
   // Upstream
   input  wire logic       i_valid,
   input  wire logic [7:0] i_data,
   output logic            o_ready,
   // Downstream
   output logic            o_valid,
   output logic      [7:0] o_data,
   input  wire logic       i_ready
);

   ndma_skid_s r_ff;
   ndma_skid_s nxt_r;
   logic       push;
   logic       pop;
   logic [1:0] slot;

   always_comb begin
      nxt_r = r_ff;
      push  = i_valid && r_ff.rdy;
      pop   = r_ff.vld && i_ready;
      slot  = r_ff.cnt - 2'(pop);
      if (pop) begin
         nxt_r.d0 = r_ff.d1;
      end
      if (push && slot == 2'h0) begin
         nxt_r.d0 = i_data;
      end
      if (push && slot == 2'h1) begin
         nxt_r.d1 = i_data;
      end
      nxt_r.cnt = slot + 2'(push);
      nxt_r.vld = nxt_r.cnt != 2'h0;
      nxt_r.rdy = nxt_r.cnt != 2'h2;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r_ff     <= '0;
         r_ff.rdy <= 1'b1;
      end else if (i_ce) begin
         r_ff <= nxt_r;
      end
   end

   assign o_ready = r_ff.rdy;
   assign o_valid = r_ff.vld;
   assign o_data  = r_ff.d0;

endmodule
`default_nettype wire

// ==== core/ndma_engine.sv ====
// Bus-master DMA engine with staging buffer for a network controller.
// Contract
// R01: Address strobe polarity follows polarity select.
// R02: Byte control on: byte pin plus A0.
// R03: Daisy chain: high mask pin becomes ack. Code does this only with byte control on as well.
// R04: DMA controller arbitration uses request, grant only.
// R05: Byte control off: masks encode lanes used.
// R06: Bus cycle at least 600ns, ready stretches.
// R07: Read: address, strobe, float, data strobe.
// R08: Latch read data as data strobe rises.
// R09: Outbound enable off before inbound on.
// R10: Write data valid before and after strobe.
// R11: Burst is eight transfers per grant.
// R12: Odd start: one byte, seven words.
// R13: Packet tail: words, then final byte.
// R14: Single word cycles, own arbitration each.
// R15: Forty-eight byte staging buffer.
// R16: Transmit request only with over 16 free.
// R17: Transmit start once first byte buffered.
// R18: Backoff fills to 32; reception wins.
// R19: Receive burst needs 16 buffered bytes.
// R20: Preamble and sync never enter buffer.
// R21: Lane swap only for buffer transfers.
// R22: Even byte low lanes; swap exchanges.
// R23: Hold request during cycles; float after release.
`include "ndma_params.svh"
`default_nettype none
module ndma_engine
   import ndma_pkg::*;
(
   // Clock and reset
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic        i_ce,
   // Configuration
   input  wire logic        i_strobe_polarity_sel,
   input  wire logic        i_byte_ctrl_sel,
   input  wire logic        i_lane_swap_sel,
   input  wire logic        i_daisy_chain_sel,
   // Single word requests
   input  wire logic        i_sgl_valid,
   input  wire logic        i_sgl_write,
   input  wire logic [23:0] i_sgl_addr,
   input  wire logic [15:0] i_sgl_wdata,
   output logic             o_sgl_done,
   output logic      [15:0] o_sgl_rdata,
   // Buffer jobs
   input  wire logic        i_buf_valid,
   input  wire logic        i_buf_to_mem,
   input  wire logic [23:0] i_buf_addr,
   input  wire logic [10:0] i_buf_len,
   output logic             o_buf_busy,
   output logic             o_buf_done,
   // Serial side
   input  wire logic        i_line_idle,
   input  wire logic        i_backoff,
   input  wire logic        i_rx_active,
   output logic             o_tx_start,
   output logic      [7:0]  o_tx_byte,
   output logic             o_tx_valid,
   input  wire logic        i_tx_ready,
   input  wire logic [7:0]  i_rx_byte,
   input  wire logic        i_rx_valid,
   input  wire logic        i_rx_in_frame,
   input  wire logic        i_rx_flush,
   output logic             o_rx_ready,
   // Memory bus
   output logic      [15:0] o_muxed_addr_data,
   output logic             o_muxed_addr_data_oe_n,
   input  wire logic [15:0] i_muxed_addr_data,
   output logic      [7:0]  o_addr_hi,
   output logic             o_read,
   output logic             o_addr_strobe,
   output logic             o_data_strobe_n,
   output logic             o_lane_mask_lo_n,
   output logic             o_lane_mask_hi_n,
   output logic             o_ctl_oe_n,
   output logic             o_bus_req_n,
   input  wire logic        i_bus_grant_n,
   input  wire logic        i_ready_n,
   output logic             o_xcvr_inbound_en_n,
   output logic             o_xcvr_outbound_en_n
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      ndma_state_e st;
      logic        spend;
      logic        single;
      logic        wr;
      logic        swap;
      logic        is_byte;
      logic [23:0] addr;
      logic [10:0] remain;
      logic [3:0]  nxfer;
      logic [4:0]  cyc;
      logic [15:0] data;
      logic [1:0]  nb;
      logic        busy;
      logic        bwr;
      logic        req_n;
      logic [15:0] ad;
      logic        ad_oe_n;
      logic [7:0]  ahi;
      logic        ctl_oe_n;
      logic        as;
      logic        as_pin;
      logic        ds_n;
      logic        rd;
      logic        bm0_n;
      logic        bm1_n;
      logic        in_n;
      logic        out_n;
      logic        sdone;
      logic [15:0] srd;
      logic        bdone;
      logic        txs;
      logic        rxr;
   } ndma_top_s;

   localparam logic [4:0] CYC_END   = 5'(`NDMA_BUS_CYC_CLKS - 2);
   localparam logic [4:0] ADDR_LAST = 5'(`NDMA_ADDR_CLKS - 1);
   localparam logic [3:0] BURST_N   = 4'(`NDMA_BURST_XFERS);

   ndma_top_s   r_ff;
   ndma_top_s   nxt_r;
   logic [5:0]  silo_cnt;
   logic [7:0]  silo_q;
   logic        silo_push;
   logic [7:0]  silo_pdata;
   logic        silo_pop;
   logic        bus_push;
   logic        bus_pop;
   logic        rx_acc;
   logic        tx_pop;
   logic        skid_rdy;
   logic        tx_ok;
   logic        rx_ok;
   logic        byte_now;
   logic [1:0]  need;
   logic [15:0] rd_w;
   logic [7:0]  rd_b;

   // ----------------------------------------------------------------
   // Staging buffer and transmit skid
   // ----------------------------------------------------------------
   // Direction follows the last buffer job, so one store serves both ways.
   assign rx_acc     = r_ff.bwr && r_ff.rxr && i_rx_valid && i_rx_in_frame; // R20
   assign tx_pop     = !r_ff.bwr && silo_cnt != 6'h00 && skid_rdy;
   assign silo_push  = r_ff.bwr ? rx_acc : bus_push;
   assign silo_pdata = r_ff.bwr ? i_rx_byte : (r_ff.nb[0] ? r_ff.data[15:8] : r_ff.data[7:0]);
   assign silo_pop   = r_ff.bwr ? bus_pop : tx_pop;

   ndma_silo u_silo ( // R15
      .i_sys_clk   (i_sys_clk),
      .i_srst      (i_srst),
      .i_ce        (i_ce),
      .i_push      (silo_push),
      .i_push_data (silo_pdata),
      .i_pop       (silo_pop),
      .o_data      (silo_q),
      .o_count     (silo_cnt)
   );

   ndma_skid u_skid (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .i_ce      (i_ce),
      .i_valid   (tx_pop),
      .i_data    (silo_q),
      .o_ready   (skid_rdy),
      .o_valid   (o_tx_valid),
      .o_data    (o_tx_byte),
      .i_ready   (i_tx_ready)
   );

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      nxt_r    = r_ff;
      nxt_r.sdone = 1'b0;
      nxt_r.bdone = 1'b0;
      bus_push = 1'b0;
      bus_pop  = 1'b0;
      need     = r_ff.is_byte ? 2'h1 : 2'h2;
      byte_now = !r_ff.single && (r_ff.addr[0] || r_ff.remain == 11'h001); // R12 R13
      tx_ok    = !r_ff.bwr && !(i_backoff && i_rx_active) // R18
                 && silo_cnt < 6'(i_backoff ? `NDMA_BACKOFF_FILL // R18
                                  : `NDMA_SILO_BYTES - `NDMA_TX_REQ_FREE); // R16
      rx_ok    = r_ff.bwr && (silo_cnt >= 6'(`NDMA_RX_BURST_MIN) // R19
                 || (i_rx_flush && silo_cnt != 6'h00));
      rd_w     = r_ff.swap ? {i_muxed_addr_data[7:0], i_muxed_addr_data[15:8]} // R22
                           : i_muxed_addr_data;
      rd_b     = (r_ff.addr[0] ^ r_ff.swap) ? i_muxed_addr_data[15:8] // R22
                                            : i_muxed_addr_data[7:0];
      if (i_sgl_valid) begin
         nxt_r.spend = 1'b1;
      end
      unique case (r_ff.st)
         st_idle: begin
            if (!r_ff.busy && i_buf_valid) begin
               nxt_r.busy   = 1'b1;
               nxt_r.bwr    = i_buf_to_mem;
               nxt_r.addr   = i_buf_addr;
               nxt_r.remain = i_buf_len;
            end else if (r_ff.spend) begin // R14
               nxt_r.spend   = i_sgl_valid;
               nxt_r.single  = 1'b1;
               nxt_r.wr      = i_sgl_write;
               nxt_r.addr    = i_sgl_addr;
               nxt_r.data    = i_sgl_wdata;
               nxt_r.swap    = 1'b0; // R21
               nxt_r.is_byte = 1'b0;
               nxt_r.req_n   = 1'b0;
               nxt_r.st      = st_req;
            end else if (r_ff.busy && (tx_ok || rx_ok)) begin
               nxt_r.single = 1'b0;
               nxt_r.wr     = r_ff.bwr;
               nxt_r.swap   = i_lane_swap_sel; // R21
               nxt_r.nxfer  = 4'h0;
               nxt_r.req_n  = 1'b0;
               nxt_r.st     = st_req;
            end
         end
         st_req: begin
            if (!i_bus_grant_n) begin // R04 R23
               nxt_r.ctl_oe_n = 1'b0;
               nxt_r.cyc      = 5'h00;
               nxt_r.nb       = 2'h0;
               nxt_r.is_byte  = byte_now;
               nxt_r.st       = (r_ff.wr && !r_ff.single) ? st_load : st_addr;
            end
         end
         st_load: begin
            if (r_ff.nb == need) begin
               nxt_r.st = st_addr;
            end else if (silo_cnt != 6'h00) begin
               bus_pop  = 1'b1;
               nxt_r.nb = r_ff.nb + 2'h1;
               if (r_ff.nb == 2'h0) begin
                  nxt_r.data = {silo_q, silo_q};
               end else begin
                  nxt_r.data[15:8] = silo_q;
               end
            end else if (i_rx_flush && r_ff.nb == 2'h1) begin
               nxt_r.is_byte = 1'b1; // R13
            end else if (i_rx_flush) begin
               nxt_r.busy  = 1'b0;
               nxt_r.bdone = 1'b1;
               nxt_r.st    = st_rel;
            end
         end
         st_addr: begin // R07
            nxt_r.ad      = r_ff.addr[15:0];
            nxt_r.ahi     = r_ff.addr[23:16];
            nxt_r.ad_oe_n = 1'b0;
            nxt_r.rd      = !r_ff.wr;
            nxt_r.out_n   = 1'b0;
            nxt_r.in_n    = 1'b1;
            nxt_r.as      = r_ff.cyc != ADDR_LAST;
            nxt_r.cyc     = r_ff.cyc + 5'h01;
            if (r_ff.cyc == ADDR_LAST) begin
               nxt_r.st = st_turn;
            end
         end
         st_turn: begin
            nxt_r.cyc = r_ff.cyc + 5'h01;
            if (r_ff.wr) begin // R10
               nxt_r.ad = r_ff.swap ? {r_ff.data[7:0], r_ff.data[15:8]} : r_ff.data; // R22
            end else begin
               nxt_r.ad_oe_n = 1'b1; // R07
               nxt_r.out_n   = 1'b1; // R09
            end
            nxt_r.st = st_strb;
         end
         st_strb: begin
            nxt_r.ds_n = 1'b0;
            nxt_r.in_n = r_ff.wr; // R09
            nxt_r.cyc  = r_ff.cyc + 5'h01;
            if (!i_ready_n && r_ff.cyc >= CYC_END) begin // R06
               nxt_r.ds_n = 1'b1; // R08
               nxt_r.st   = st_hold;
               if (!r_ff.wr && r_ff.single) begin
                  nxt_r.srd = i_muxed_addr_data;
               end else if (!r_ff.wr) begin // R08
                  nxt_r.data = r_ff.is_byte ? {8'h00, rd_b} : rd_w;
               end
            end
         end
         st_hold: begin
            nxt_r.in_n   = 1'b1;
            nxt_r.nb     = 2'h0;
            nxt_r.addr   = r_ff.addr + 24'(need);
            nxt_r.remain = r_ff.remain - 11'(need);
            nxt_r.nxfer  = r_ff.nxfer + 4'h1;
            if (r_ff.single) begin
               nxt_r.sdone = 1'b1;
               nxt_r.st    = st_rel; // R14
            end else begin
               nxt_r.st = r_ff.wr ? st_next : st_push;
            end
         end
         st_push: begin
            if (silo_cnt != 6'(`NDMA_SILO_BYTES)) begin
               bus_push = 1'b1;
               nxt_r.nb = r_ff.nb + 2'h1;
               if (r_ff.nb + 2'h1 == need) begin
                  nxt_r.st = st_next;
               end
            end
         end
         st_next: begin
            nxt_r.cyc     = 5'h00;
            nxt_r.nb      = 2'h0;
            nxt_r.is_byte = byte_now;
            if (r_ff.remain == 11'h000) begin
               nxt_r.busy  = 1'b0;
               nxt_r.bdone = 1'b1;
               nxt_r.st    = st_rel;
            end else if (r_ff.nxfer == BURST_N || i_bus_grant_n) begin // R11 R23
               nxt_r.st = st_rel;
            end else begin
               nxt_r.st = r_ff.wr ? st_load : st_addr;
            end
         end
         st_rel: begin // R23
            nxt_r.req_n    = 1'b1;
            nxt_r.ctl_oe_n = 1'b1;
            nxt_r.ad_oe_n  = 1'b1;
            nxt_r.in_n     = 1'b1;
            nxt_r.out_n    = 1'b1;
            nxt_r.as       = 1'b0;
            nxt_r.ds_n     = 1'b1;
            nxt_r.st       = st_idle;
         end
         default: begin
            nxt_r.st = st_rel;
         end
      endcase
      nxt_r.as_pin = nxt_r.as ^ i_strobe_polarity_sel; // R01
      nxt_r.bm0_n  = i_byte_ctrl_sel ? !nxt_r.is_byte // R02
                                     : nxt_r.is_byte && nxt_r.addr[0]; // R05
      nxt_r.bm1_n  = (i_byte_ctrl_sel && i_daisy_chain_sel) ? nxt_r.ctl_oe_n // R03
                                     : nxt_r.is_byte && !nxt_r.addr[0]; // R05
      nxt_r.txs    = !r_ff.bwr && i_line_idle // R17
                     && (silo_cnt != 6'h00 || o_tx_valid);
      nxt_r.rxr    = r_ff.bwr && silo_cnt < 6'(`NDMA_RX_STOP_LEVEL);
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         r_ff          <= '0;
         r_ff.st       <= st_idle;
         r_ff.req_n    <= `NDMA_RST_ACT_LOW;
         r_ff.ad_oe_n  <= `NDMA_RST_ACT_LOW;
         r_ff.ctl_oe_n <= `NDMA_RST_ACT_LOW;
         r_ff.ds_n     <= `NDMA_RST_ACT_LOW;
         r_ff.bm0_n    <= `NDMA_RST_ACT_LOW;
         r_ff.bm1_n    <= `NDMA_RST_ACT_LOW;
         r_ff.in_n     <= `NDMA_RST_ACT_LOW;
         r_ff.out_n    <= `NDMA_RST_ACT_LOW;
         r_ff.as_pin   <= `NDMA_RST_ACT_HIGH;
      end else if (i_ce) begin
         r_ff <= nxt_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign o_sgl_done             = r_ff.sdone;
   assign o_sgl_rdata            = r_ff.srd;
   assign o_buf_busy             = r_ff.busy;
   assign o_buf_done             = r_ff.bdone;
   assign o_tx_start             = r_ff.txs;
   assign o_rx_ready             = r_ff.rxr;
   assign o_muxed_addr_data      = r_ff.ad;
   assign o_muxed_addr_data_oe_n = r_ff.ad_oe_n;
   assign o_addr_hi              = r_ff.ahi;
   assign o_read                 = r_ff.rd;
   assign o_addr_strobe          = r_ff.as_pin;
   assign o_data_strobe_n        = r_ff.ds_n;
   assign o_lane_mask_lo_n       = r_ff.bm0_n;
   assign o_lane_mask_hi_n       = r_ff.bm1_n;
   assign o_ctl_oe_n             = r_ff.ctl_oe_n;
   assign o_bus_req_n            = r_ff.req_n;
   assign o_xcvr_inbound_en_n    = r_ff.in_n;
   assign o_xcvr_outbound_en_n   = r_ff.out_n;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst || !i_ce);

   chk_strobe_polarity: assert property ((r_ff.st == st_turn) // R01
      |-> o_addr_strobe == i_strobe_polarity_sel) else $error("strobe level");
   chk_cycle_min: assert property ($rose(o_data_strobe_n) && !o_ctl_oe_n // R06
      |-> r_ff.cyc >= 5'(`NDMA_BUS_CYC_CLKS - 1)) else $error("short cycle");
   chk_ready_latch: assert property ($rose(o_data_strobe_n) && !o_ctl_oe_n // R08
      |-> !$past(i_ready_n)) else $error("strobe rose without ready");
   chk_xcvr_order: assert property ($fell(o_xcvr_inbound_en_n) // R09
      |-> o_xcvr_outbound_en_n && $past(o_xcvr_outbound_en_n)) else $error("xcvr overlap");
   chk_write_hold: assert property (!o_data_strobe_n && !o_read // R10
      |-> !o_muxed_addr_data_oe_n ##1 !o_muxed_addr_data_oe_n) else $error("write data");
   chk_burst_len: assert property (r_ff.nxfer <= BURST_N) else $error("burst too long"); // R11
   chk_odd_byte: assert property ((r_ff.st == st_addr) && !r_ff.single // R12
      && r_ff.addr[0] |-> r_ff.is_byte) else $error("odd start not byte");
   chk_mask_word: assert property ((r_ff.st == st_turn) && !i_byte_ctrl_sel // R05
      && !r_ff.is_byte |-> !o_lane_mask_lo_n && !o_lane_mask_hi_n) else $error("mask");
   chk_req_held: assert property (!o_data_strobe_n |-> !o_bus_req_n) else $error("req"); // R23
   chk_float_release: assert property ($rose(o_bus_req_n) // R23
      |-> o_muxed_addr_data_oe_n && o_ctl_oe_n) else $error("bus not floated");
   chk_tx_request: assert property ($fell(o_bus_req_n) && !r_ff.single && !r_ff.wr // R16
      |-> $past(silo_cnt) < 6'(`NDMA_BACKOFF_FILL)) else $error("tx request full");

   cov_full_burst: cover property ((r_ff.st == st_next) && r_ff.nxfer == BURST_N);
   cov_single_read: cover property (o_sgl_done && !r_ff.wr);
   cov_byte_xfer: cover property ((r_ff.st == st_hold) && r_ff.is_byte);
   cov_stretch: cover property ((r_ff.st == st_strb) && r_ff.cyc > CYC_END + 5'h02);

endmodule
`default_nettype wire

// ==== bench/ndma_mem_model.sv ====
// Memory and bus arbiter model at the far side of the DMA engine.
`default_nettype none
module ndma_mem_model #(
   parameter int WAIT = 20
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_pol,
   input  wire logic        i_req_n,
   input  wire logic        i_as,
   input  wire logic        i_ds_n,
   input  wire logic        i_rd,
   input  wire logic        i_lo_n,
   input  wire logic        i_hi_n,
   input  wire logic [15:0] i_dal,
   output logic      [15:0] o_dal,
   output logic             o_grant_n,
   output logic             o_ready_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [256];
   logic [7:0]  a = 8'h00;
   int          n = 0;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = {8'(2 * i + 1), 8'(2 * i)};
      o_dal = 16'h0000;
      o_grant_n = 1'b1;
      o_ready_n = 1'b1;
   end
   always @(posedge i_sys_clk) begin
      o_grant_n <= i_req_n;
      if (i_as != i_pol) a <= i_dal[8:1];
      if (i_ds_n) begin
         // Released lines toggle so a stale value is never mistaken for data.
         n <= 0;
         o_ready_n <= 1'b1;
         o_dal <= ~o_dal;
      end else begin
         n <= n + 1;
         o_ready_n <= !(n >= WAIT);
         if (i_rd) o_dal <= mem[a];
         else if (!o_ready_n && !i_lo_n) mem[a][7:0] <= i_dal[7:0];
         if (!i_rd && !o_ready_n && !i_hi_n) mem[a][15:8] <= i_dal[15:8];
      end
   end
endmodule
`default_nettype wire

// ==== bench/ndma_engine_tb.sv ====
// Self-checking testbench of the network DMA engine.
`default_nettype none
module ndma_engine_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, ce = 1, pol = 0, bc = 0, dc = 0, swp = 0, sv = 0, sw = 0, bv = 0;
   logic tm = 0, idl = 1, bo = 0, ra = 0, rv = 0, rf = 0, fl = 0, txr = 1;
   logic [23:0] sa = 0;
   logic [15:0] sd = 0;
   logic [7:0]  rb = 0;
   wire rr, bd;
   wire [15:0] dal_o, dal_i, rdat;
   wire [7:0]  txb;
   wire oe_n, as_p, ds_n, lo_n, hi_n, req_n, gnt_n, rdy_n, rd, done, busy, ts, tv, in_n, out_n;
   int failures = 0, n_tests = 0;
   always #20 clk = ~clk;
   ndma_engine u_ndma_engine (.i_sys_clk(clk), .i_srst(rst), .i_ce(ce),
      .i_strobe_polarity_sel(pol), .i_byte_ctrl_sel(bc), .i_lane_swap_sel(swp),
      .i_daisy_chain_sel(dc), .i_sgl_valid(sv), .i_sgl_write(sw), .i_sgl_addr(sa),
      .i_sgl_wdata(sd), .o_sgl_done(done), .o_sgl_rdata(rdat), .i_buf_valid(bv),
      .i_buf_to_mem(tm), .i_buf_addr(24'h000005), .i_buf_len(11'h005), .o_buf_busy(busy),
      .o_buf_done(bd), .i_line_idle(idl), .i_backoff(bo), .i_rx_active(ra), .o_tx_start(ts),
      .o_tx_byte(txb), .o_tx_valid(tv), .i_tx_ready(txr), .i_rx_byte(rb),
      .i_rx_valid(rv), .i_rx_in_frame(rf), .i_rx_flush(fl), .o_rx_ready(rr),
      .o_muxed_addr_data(dal_o), .o_muxed_addr_data_oe_n(oe_n), .i_muxed_addr_data(dal_i),
      .o_addr_hi(), .o_read(rd), .o_addr_strobe(as_p), .o_data_strobe_n(ds_n),
      .o_lane_mask_lo_n(lo_n), .o_lane_mask_hi_n(hi_n), .o_ctl_oe_n(), .o_bus_req_n(req_n),
      .i_bus_grant_n(gnt_n), .i_ready_n(rdy_n), .o_xcvr_inbound_en_n(in_n),
      .o_xcvr_outbound_en_n(out_n));
   ndma_mem_model u_ndma_mem_model (.i_sys_clk(clk), .i_pol(pol), .i_req_n(req_n),
      .i_as(as_p), .i_ds_n(ds_n), .i_rd(rd), .i_lo_n(lo_n), .i_hi_n(hi_n), .i_dal(dal_o),
      .o_dal(dal_i), .o_grant_n(gnt_n), .o_ready_n(rdy_n));
   task automatic check(string nm, logic [15:0] e, logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // A single word cycle; the slow memory model stretches every strobe.
   task automatic sgl(logic w, logic [23:0] a, logic [15:0] d);
      int k = 0;
      int nd = 0;
      @(posedge clk) #1;
      sv = 1;
      sw = w;
      sa = a;
      sd = d;
      @(posedge clk) #1;
      sv = 0;
      while (done !== 1'b1) begin
         @(posedge clk) #2;
         nd += int'(ds_n === 1'b0);
         if (!w && ds_n === 1'b0) check("float", 1, oe_n);
         check("xcvr", 1, in_n | out_n);
         k++;
         if (k > 400) begin
            failures++;
            complete_run();
         end
      end
      check("ds_len", 1, nd > 20);
      @(posedge clk) #2;
      check("release", 16'h0003, {14'h0, req_n, oe_n});
   endtask
   task automatic t_tx(logic s);
      int k, i = 0;
      logic st = 0;
      @(posedge clk) #1;
      {swp, bc, dc, bo, ra, bv} = {{5{s}}, 1'b1};
      @(posedge clk) #1;
      bv = 0;
      if (s) begin
         repeat (20) @(posedge clk);
         #1 check("rx_first", 1, req_n);
         ra = 0;
      end
      for (k = 0; k < 3000 && i < 5; k++) begin
         @(posedge clk) #2;
         st |= (ts === 1'b1);
         if (s && ds_n === 1'b0) check("chain_ack", 0, hi_n);
         if (tv === 1'b1) begin
            check("tx_byte", 16'(8'(5 + i) ^ {7'h00, s}), 16'(txb));
            i++;
         end
      end
      check("tx_count", 5, 16'(i));
      check("tx_start", 1, st);
      for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge clk) #2;
      check("busy", 0, busy);
   endtask
   // Receive job of five bytes to an odd address; a byte outside the frame is offered first.
   task automatic t_rx();
      int k;
      logic d = 0;
      @(posedge clk) #1;
      {swp, bc, dc, bo, tm, bv} = 6'b000011;
      @(posedge clk) #1;
      {bv, rv, rb} = {2'b01, 8'h77};
      repeat (2) @(posedge clk) #1;
      rf = 1;
      for (k = 0; k < 5; k++) begin
         rb = 8'(8'ha0 + k);
         @(posedge clk) #1;
      end
      {rv, rf} = 2'b00;
      repeat (20) @(posedge clk) #1;
      check("rx_wait", 16'h0003, {14'h0, req_n, rr});
      fl = 1;
      for (k = 0; k < 800 && busy !== 1'b0; k++) begin
         @(posedge clk) #2;
         d |= (bd === 1'b1);
      end
      @(posedge clk) #1 fl = 0;
      check("rx_done", 1, d);
      sgl(0, 24'h000004, 16'h0000);
      check("rx_odd", 16'ha004, rdat);
      sgl(0, 24'h000006, 16'h0000);
      check("rx_word", 16'ha2a1, rdat);
      sgl(0, 24'h000008, 16'h0000);
      check("rx_tail", 16'ha4a3, rdat);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      #1 rst = 0;
      #1 check("idle_bus", 16'h000e, {12'h0, req_n, oe_n, ds_n, busy});
      sgl(1, 24'h000040, 16'hbeef);
      sgl(0, 24'h000040, 16'h0000);
      check("rdata", 16'hbeef, rdat);
      swp = 1;
      pol = 1;
      sgl(0, 24'h000042, 16'h0000);
      check("no_swap", 16'h4342, rdat);
      t_tx(0);
      t_tx(1);
      t_rx();
      complete_run();
   end
endmodule
`default_nettype wire
